// *** verilog/cfhbs_top.sv ***
// Destination select for acceptance filters 12 to 15.
`timescale 1ns/1ps
`default_nettype none
module cfhbs_top (
   // Clock and reset
   input  wire logic                    core_clk_in,
   input  wire logic                    arst_n_in,
   // Register port
   input  wire logic [3:0]              reg_addr_in,
   input  wire logic [15:0]             reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic [15:0]                  reg_rdata_out,
   // Filter hit from the matching logic
   input  wire cfhbs_pkg::cfhbs_hit_type hit_in,
   // Destination to the storage logic
   output var cfhbs_pkg::cfhbs_dest_type dest_out
);

   // ---------------------------------------------------------------
   // Pointer register
   // ---------------------------------------------------------------
   logic [15:0]                 ptr_reg;
   logic [15:0]                 rdata_reg;
   logic [3:0]                  field_sel;
   logic                        hit_ours;
   cfhbs_pkg::cfhbs_dest_type   dest_next;
   cfhbs_pkg::cfhbs_dest_type   dest_reg;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ptr_reg <= cfhbs_pkg::PTR_REG_RESET;
      end else if (reg_wr_in && reg_addr_in == cfhbs_pkg::PTR_REG_OFFSET) begin
         ptr_reg <= reg_wdata_in;
      end
   end

   // Unmapped addresses read as zero.
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd_in) begin
         rdata_reg <= (reg_addr_in == cfhbs_pkg::PTR_REG_OFFSET) ?
                      ptr_reg : 16'h0000;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end
   assign reg_rdata_out = rdata_reg;

   // ---------------------------------------------------------------
   // Field selection
   // ---------------------------------------------------------------
   // Hits on filters 0 to 11 belong to other pointer registers.
   assign hit_ours = hit_in.hit && (hit_in.filter >= cfhbs_pkg::FIRST_FILTER);

   always_comb begin
      case (hit_in.filter)
         4'hf:    field_sel = ptr_reg[cfhbs_pkg::F15_LSB +: cfhbs_pkg::FIELD_W];
         4'he:    field_sel = ptr_reg[cfhbs_pkg::F14_LSB +: cfhbs_pkg::FIELD_W];
         4'hd:    field_sel = ptr_reg[cfhbs_pkg::F13_LSB +: cfhbs_pkg::FIELD_W];
         4'hc:    field_sel = ptr_reg[cfhbs_pkg::F12_LSB +: cfhbs_pkg::FIELD_W];
         default: field_sel = 4'h0;
      endcase
   end

   cfhbs_decode u_decode (
      .field_in (field_sel),
      .hit_in   (hit_ours),
      .dest_out (dest_next)
   );

   // The destination is registered so storage sees a clean value.
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dest_reg <= '0;
      end else begin
         dest_reg <= dest_next;
      end
   end
   assign dest_out = dest_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_f15_select: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_in.hit && hit_in.filter == 4'hf |=> dest_out.valid &&
      (dest_out.to_fifo ? $past(ptr_reg[15:12]) == 4'hf
                        : dest_out.buffer == $past(ptr_reg[15:12])))
      else $error("filter 15 destination wrong");
   chk_f14_select: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_in.hit && hit_in.filter == 4'he |=>
      dest_out.buffer == $past(ptr_reg[11:8]))
      else $error("filter 14 destination wrong");
   chk_f13_select: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_in.hit && hit_in.filter == 4'hd |=>
      dest_out.buffer == $past(ptr_reg[7:4]))
      else $error("filter 13 destination wrong");
   chk_f12_select: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_in.hit && hit_in.filter == 4'hc |=>
      dest_out.buffer == $past(ptr_reg[3:0]))
      else $error("filter 12 destination wrong");
   chk_fifo_code: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      dest_out.valid |-> dest_out.to_fifo == (dest_out.buffer == 4'hf))
      else $error("fifo routing wrong");
   chk_buf14_code: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_ours && field_sel == 4'he |=> dest_out.valid && !dest_out.to_fifo
      && dest_out.buffer == 4'he)
      else $error("buffer 14 routing wrong");
   chk_low_codes: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_ours && field_sel <= 4'h1 |=> !dest_out.to_fifo &&
      dest_out.buffer == $past(field_sel))
      else $error("buffer 0 or 1 routing wrong");
   chk_mid_codes: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_ours && field_sel inside {[4'h2:4'hd]} |=> dest_out.valid &&
      !dest_out.to_fifo && dest_out.buffer == $past(field_sel))
      else $error("numbered buffer routing wrong");
   chk_no_foreign: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !hit_ours |=> !dest_out.valid)
      else $error("destination for foreign filter");

   // ---------------------------------------------------------------
   // Register bus checks
   // ---------------------------------------------------------------
   chk_rd_answer: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      reg_rd_in && reg_addr_in == cfhbs_pkg::PTR_REG_OFFSET |=>
      reg_rdata_out == $past(ptr_reg))
      else $error("read data wrong");
   chk_rd_unmapped: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      reg_rd_in && reg_addr_in != cfhbs_pkg::PTR_REG_OFFSET |=>
      reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   chk_rd_idle: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data outside read cycle");
   chk_wr_lands: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      reg_wr_in && reg_addr_in == cfhbs_pkg::PTR_REG_OFFSET |=>
      ptr_reg == $past(reg_wdata_in))
      else $error("write did not land");
   chk_wr_ignored: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !(reg_wr_in && reg_addr_in == cfhbs_pkg::PTR_REG_OFFSET) |=>
      $stable(ptr_reg))
      else $error("pointer changed without write");

   cov_fifo: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
      dest_out.valid && dest_out.to_fifo);
   cov_buf: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
      dest_out.valid && !dest_out.to_fifo);
   cov_write_hit: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
      reg_wr_in ##1 hit_ours);
   cov_foreign_hit: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_in.hit && !hit_ours);
   cov_back_to_back: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
      hit_ours ##1 hit_ours);

endmodule : cfhbs_top
`default_nettype wire

// *** verilog/cfhbs_pkg.sv ***
// Package for the filter 12 to 15 destination select block.
`default_nettype none
package cfhbs_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0]  PTR_REG_OFFSET   = 4'h0;
   localparam logic [15:0] PTR_REG_RESET    = 16'h0000;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int          F12_LSB          = 0;
   localparam int          F13_LSB          = 4;
   localparam int          F14_LSB          = 8;
   localparam int          F15_LSB          = 12;
   localparam int          FIELD_W          = 4;
   localparam logic [3:0]  FIRST_FILTER     = 4'hc;
   localparam logic [3:0]  DEST_FIFO_CODE   = 4'hf;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       hit;
      logic [3:0] filter;
   } cfhbs_hit_type;

   typedef struct packed {
      logic       valid;
      logic       to_fifo;
      logic [3:0] buffer;
   } cfhbs_dest_type;

endpackage : cfhbs_pkg
`default_nettype wire

// *** verilog/cfhbs_decode.sv ***
// Decoder that turns one pointer field into a destination.
`timescale 1ns/1ps
`default_nettype none
module cfhbs_decode (
   // Field in
   input  wire logic [3:0]              field_in,
   input  wire logic                    hit_in,
   // Destination out
   output var cfhbs_pkg::cfhbs_dest_type dest_out
);
   always_comb begin
      dest_out.valid   = hit_in;
      dest_out.to_fifo = (field_in == cfhbs_pkg::DEST_FIFO_CODE);
      // All other codes name the buffer with that number.
      dest_out.buffer  = field_in;
   end
endmodule : cfhbs_decode
`default_nettype wire

// *** test/cfhbs_tb.sv ***
// Self-checking bench for the filter 12 to 15 destination select block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                      core_clk_in  = 1'b0;
   logic                      arst_n_in    = 1'b0;
   logic [3:0]                reg_addr_in  = 4'h0;
   logic [15:0]               reg_wdata_in = 16'h0000;
   logic                      reg_wr_in    = 1'b0;
   logic                      reg_rd_in    = 1'b0;
   logic [15:0]               reg_rdata_out;
   cfhbs_pkg::cfhbs_hit_type  hit_in       = '0;
   cfhbs_pkg::cfhbs_dest_type dest_out;
   int                        failures     = 0;
   int                        comparisons  = 0;
   int                        cycles       = 0;
   logic [15:0]               rows [4] = '{16'hfe10, 16'h2345, 16'h6789,
                                           16'habcd};
   cfhbs_top cfhbs_top_inst (.core_clk_in, .arst_n_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .hit_in,
      .dest_out);
   always #10 core_clk_in = ~core_clk_in;
   // The ceiling sits well above the roughly 80 cycles the tests need.
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_data
   task automatic chk_dest(input cfhbs_pkg::cfhbs_dest_type got,
                           input cfhbs_pkg::cfhbs_dest_type exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_dest
   function automatic cfhbs_pkg::cfhbs_dest_type exp_dest(
      input logic [15:0] p, input logic [3:0] f);
      logic [3:0] fld;
      fld = p[4*(int'(f)-12) +: 4];
      return {1'b1, fld == 4'hf, fld};
   endfunction : exp_dest
   // Tasks leave a idle cycle at their end so strobes never double up.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge core_clk_in);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] got);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 got = reg_rdata_out;
      @(posedge core_clk_in);
   endtask : rd
   task automatic hit(input logic [3:0] f,
                      output cfhbs_pkg::cfhbs_dest_type d);
      hit_in <= {1'b1, f};
      @(posedge core_clk_in);
      hit_in <= '0;
      #1 d = dest_out;
      @(posedge core_clk_in);
   endtask : hit
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      logic [15:0]               r;
      cfhbs_pkg::cfhbs_dest_type d;
      repeat (8) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      @(posedge core_clk_in);
      rd(4'h0, r);
      chk_data(r, 16'h0000);
      foreach (rows[i]) begin
         wr(4'h0, rows[i]);
         rd(4'h0, r);
         chk_data(r, rows[i]);
         for (int f = 12; f < 16; f++) begin
            hit(4'(f), d);
            chk_dest(d, exp_dest(rows[i], 4'(f)));
         end
      end
      wr(4'h3, 16'h1111);
      rd(4'h3, r);
      chk_data(r, 16'h0000);
      rd(4'h0, r);
      chk_data(r, rows[3]);
      hit(4'hb, d);
      chk_data({15'h0000, d.valid}, 16'h0000);
      // A write beside a hit must leave that hit on the old field.
      reg_wdata_in <= 16'he000;
      reg_wr_in    <= 1'b1;
      hit_in       <= {1'b1, 4'hf};
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      hit_in    <= {1'b1, 4'hc};
      #1 chk_dest(dest_out, exp_dest(16'habcd, 4'hf));
      @(posedge core_clk_in);
      hit_in <= '0;
      #1 chk_dest(dest_out, exp_dest(16'he000, 4'hc));
      @(posedge core_clk_in);
      // A reset in mid-run must clear the pointer and the outputs.
      arst_n_in <= 1'b0;
      @(posedge core_clk_in);
      #1 chk_dest(dest_out, '0);
      chk_data(reg_rdata_out, 16'h0000);
      @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      @(posedge core_clk_in);
      rd(4'h0, r);
      chk_data(r, cfhbs_pkg::PTR_REG_RESET);
      hit(4'hf, d);
      chk_dest(d, exp_dest(cfhbs_pkg::PTR_REG_RESET, 4'hf));
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
